/* File: rtl/brpc_top.sv */
// Two-channel receiver pin control with AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`include "brpc_defs.svh"

// Contract
// - Default transceiver master clock is internal master clock divided by 100.
// - Source select 1 takes master clock from the external master clock pin.
// - Source select 0 ignores external pin; board ties it high or low.
// - Recovered clock enable drives the recovered clock on its output pin.
// - Recovered clock routes to one of fourteen input slots regardless of pin.
// - Disabled recovered clock pin drives the inversion bit level.
// - Multipurpose output driven when enabled, from frame or multiframe sync.
// - Disabled multipurpose output drives its inversion bit level.
// - Mode 0x outputs received stream as NRZ on serial data pin.
// - Serial data changes on the recovered clock edge picked by inversion bit.
// - Serial data driven only when enabled; low outside DS1/E1 modes.
// - Power-down stops receiving and puts line inputs in high impedance.
module brpc_top #(
    parameter int ADDR_W = 8,
    parameter int MCLK_DIV = `BRPC_MCLK_DIV,
    parameter int BUF_DEPTH = `BRPC_BUF_DEPTH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Master clocks
    input wire logic int_master_tick,
    input wire logic [1:0] ext_master_clk_in,
    output logic [1:0] xcvr_mclk_tick,
    // Receiver side
    input wire logic [1:0] rec_clk_in,
    input wire logic [1:0] frame_sync_in,
    input wire logic [1:0] mframe_sync_in,
    input wire logic [1:0] rx_bit_in,
    input wire logic [1:0] rx_bit_valid,
    output wire logic [1:0] rx_bit_ready,
    input wire logic [1:0] rx_line_pos,
    input wire logic [1:0] rx_line_neg,
    // Board pins
    output logic [1:0] recovered_clk_out,
    output logic [1:0][`BRPC_NUM_SLOT-1:0] ic_slot_clk,
    output logic [1:0] rx_multipurpose_out,
    output logic [1:0] rx_serial_data_out,
    output logic [1:0] rx_line_hiz
);

    localparam int NUM_CH = `BRPC_NUM_CH;
    localparam int DIV_W = $clog2(MCLK_DIV);

    brpc_pkg::brpc_chan_cfg_t cfg_q [NUM_CH];
    brpc_pkg::brpc_chan_cfg_t cfg_d [NUM_CH];
    brpc_pkg::brpc_bus_st_t wst_q, wst_d, rst_q, rst_d;
    brpc_pkg::brpc_dec_t wdec, rdec;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [31:0] wdat_q, wdat_d, rdata_d, status;
    logic [3:0] wstb_q, wstb_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [DIV_W-1:0] div_cnt_q [NUM_CH];
    logic [DIV_W-1:0] div_cnt_d [NUM_CH];
    logic [1:0] div_hit, ext_rise, upd_edge, mode_ok, drain;
    logic [1:0] ext_prev_q, rc_prev_q, lp_q, ln_q, lp_d, ln_d;
    logic [1:0] mclk_d, rclk_d, mp_d, ser_d, hiz_d;
    logic [1:0][`BRPC_NUM_SLOT-1:0] slot_d;
    wire [1:0] buf_valid;
    wire [1:0] buf_data;

    // ****************************************
    // Decode and register access
    // ****************************************
    function automatic brpc_pkg::brpc_dec_t brpc_decode(input logic [ADDR_W-1:0] a);
        brpc_pkg::brpc_dec_t d;
        d = '0;
        if (a[1:0] == 2'h0 && a < ADDR_W'(`BRPC_OFF_STATUS))
        begin
            d.hit = 1'b1;
            d.ch = a[4];
            d.idx = a[3:2];
        end
        else if (a == ADDR_W'(`BRPC_OFF_STATUS))
        begin
            d.hit = 1'b1;
            d.status = 1'b1;
        end
        return d;
    endfunction : brpc_decode

    function automatic logic [31:0] brpc_reg_read(input brpc_pkg::brpc_chan_cfg_t c,
                                                  input logic [1:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (idx)
            `BRPC_IDX_CLK_CTRL: v[`BRPC_CLK_CTRL_W-1:0] = c.clk;
            `BRPC_IDX_CLK_ROUTE: v[`BRPC_DEST_W-1:0] = c.dest;
            `BRPC_IDX_LINE_MODE: v[`BRPC_MODE_W-1:0] = c.mode;
            `BRPC_IDX_LINE_IF: v[0] = c.pd;
        endcase
        return v;
    endfunction : brpc_reg_read

    function automatic brpc_pkg::brpc_chan_cfg_t brpc_reg_write(
        input brpc_pkg::brpc_chan_cfg_t c, input logic [1:0] idx, input logic [31:0] v);
        brpc_pkg::brpc_chan_cfg_t n;
        n = c;
        unique case (idx)
            `BRPC_IDX_CLK_CTRL: n.clk = v[`BRPC_CLK_CTRL_W-1:0];
            `BRPC_IDX_CLK_ROUTE: n.dest = v[`BRPC_DEST_W-1:0];
            `BRPC_IDX_LINE_MODE: n.mode = v[`BRPC_MODE_W-1:0];
            `BRPC_IDX_LINE_IF: n.pd = v[0];
        endcase
        return n;
    endfunction : brpc_reg_write

    function automatic logic [`BRPC_NUM_SLOT-1:0] brpc_slot_mask(input logic [3:0] dest,
                                                                 input logic clk);
        logic [`BRPC_NUM_SLOT-1:0] m;
        m = '0;
        for (int k = 0; k < `BRPC_NUM_SLOT; k++)
        begin
            m[k] = clk && (dest == 4'(k + 1));
        end
        return m;
    endfunction : brpc_slot_mask

    // ****************************************
    // Bus slave next state
    // ****************************************
    always_comb
    begin
        cfg_d = cfg_q;
        wst_d = wst_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wdat_d = wdat_q;
        wstb_d = wstb_q;
        bvalid_d = bvalid;
        bresp_d = bresp;
        wdec = '0;
        unique case (wst_q)
            brpc_pkg::BRPC_ST_IDLE:
            begin
                if (awvalid && awready)
                begin
                    aw_got_d = 1'b1;
                    waddr_d = awaddr;
                end
                if (wvalid && wready)
                begin
                    w_got_d = 1'b1;
                    wdat_d = wdata;
                    wstb_d = wstrb;
                end
                if (aw_got_d && w_got_d)
                begin
                    wdec = brpc_decode(waddr_d);
                    if (wdec.hit && !wdec.status && wstb_d[0])
                    begin
                        cfg_d[wdec.ch] = brpc_reg_write(cfg_q[wdec.ch], wdec.idx, wdat_d);
                    end
                    bresp_d = wdec.hit ? `BRPC_RESP_OKAY : `BRPC_RESP_SLVERR;
                    bvalid_d = 1'b1;
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = brpc_pkg::BRPC_ST_RESP;
                end
            end
            brpc_pkg::BRPC_ST_RESP:
            begin
                if (bready)
                begin
                    bvalid_d = 1'b0;
                    wst_d = brpc_pkg::BRPC_ST_IDLE;
                end
            end
            default: wst_d = brpc_pkg::BRPC_ST_IDLE;
        endcase
        awready_d = (wst_d == brpc_pkg::BRPC_ST_IDLE) && !aw_got_d;
        wready_d = (wst_d == brpc_pkg::BRPC_ST_IDLE) && !w_got_d;

        status = 32'h0000_0000;
        for (int c = 0; c < NUM_CH; c++)
        begin
            status[c*`BRPC_STATUS_CH_W +: `BRPC_STATUS_CH_W] =
                {2'h0, rx_line_hiz[c], ln_q[c], lp_q[c], rx_bit_ready[c], buf_valid[c],
                 cfg_q[c].clk.mclk_sel};
        end
        rst_d = rst_q;
        rvalid_d = rvalid;
        rdata_d = rdata;
        rresp_d = rresp;
        rdec = brpc_decode(araddr);
        unique case (rst_q)
            brpc_pkg::BRPC_ST_IDLE:
            begin
                if (arvalid && arready)
                begin
                    rdata_d = !rdec.hit ? 32'h0000_0000 :
                              rdec.status ? status : brpc_reg_read(cfg_q[rdec.ch], rdec.idx);
                    rresp_d = rdec.hit ? `BRPC_RESP_OKAY : `BRPC_RESP_SLVERR;
                    rvalid_d = 1'b1;
                    rst_d = brpc_pkg::BRPC_ST_RESP;
                end
            end
            brpc_pkg::BRPC_ST_RESP:
            begin
                if (rready)
                begin
                    rvalid_d = 1'b0;
                    rst_d = brpc_pkg::BRPC_ST_IDLE;
                end
            end
            default: rst_d = brpc_pkg::BRPC_ST_IDLE;
        endcase
        arready_d = (rst_d == brpc_pkg::BRPC_ST_IDLE);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                cfg_q[c] <= {`BRPC_RST_CLK_CTRL, `BRPC_RST_DEST, `BRPC_RST_MODE, `BRPC_RST_PD};
            end
            wst_q <= brpc_pkg::BRPC_ST_IDLE;
            rst_q <= brpc_pkg::BRPC_ST_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= '0;
            wdat_q <= 32'h0000_0000;
            wstb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `BRPC_RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `BRPC_RESP_OKAY;
        end
        else
        begin
            cfg_q <= cfg_d;
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdat_q <= wdat_d;
            wstb_q <= wstb_d;
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rdata <= rdata_d;
            rresp <= rresp_d;
        end
    end

    // ****************************************
    // Payload buffers, one per channel
    // ****************************************
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_buf
        brpc_buf #(.W(1), .DEPTH(BUF_DEPTH)) u_buf (
            .aclk(aclk),
            .aresetn(aresetn),
            .in_valid(rx_bit_valid[g] && !cfg_q[g].pd),
            .in_data(rx_bit_in[g]),
            .in_ready(rx_bit_ready[g]),
            .out_valid(buf_valid[g]),
            .out_data(buf_data[g]),
            .out_ready(drain[g])
        );
    end

    // ****************************************
    // Channel pin logic next state
    // ****************************************
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            div_hit[c] = int_master_tick && (div_cnt_q[c] == DIV_W'(MCLK_DIV - 1));
            div_cnt_d[c] = !int_master_tick ? div_cnt_q[c] :
                           div_hit[c] ? '0 : DIV_W'(div_cnt_q[c] + 1'b1);
            ext_rise[c] = ext_master_clk_in[c] && !ext_prev_q[c];
            mclk_d[c] = cfg_q[c].clk.mclk_sel ? ext_rise[c] : div_hit[c];
            upd_edge[c] = cfg_q[c].clk.rc_inv ? (!rec_clk_in[c] && rc_prev_q[c]) :
                                                (rec_clk_in[c] && !rc_prev_q[c]);
            mode_ok[c] = !cfg_q[c].mode[`BRPC_MODE_NRZ_BIT];
            drain[c] = upd_edge[c] && mode_ok[c] && !cfg_q[c].pd;
            rclk_d[c] = cfg_q[c].clk.rc_en ? rec_clk_in[c] : cfg_q[c].clk.rc_inv;
            slot_d[c] = cfg_q[c].pd ? '0 : brpc_slot_mask(cfg_q[c].dest, rec_clk_in[c]);
            mp_d[c] = !cfg_q[c].clk.ro_en ? cfg_q[c].clk.ro_inv :
                      cfg_q[c].clk.ro_src ? mframe_sync_in[c] : frame_sync_in[c];
            if (!mode_ok[c] || !cfg_q[c].clk.rs_en)
            begin
                ser_d[c] = 1'b0;
            end
            else if (drain[c] && buf_valid[c])
            begin
                ser_d[c] = buf_data[c];
            end
            else
            begin
                ser_d[c] = rx_serial_data_out[c];
            end
            hiz_d[c] = cfg_q[c].pd;
            lp_d[c] = rx_line_pos[c] && !cfg_q[c].pd;
            ln_d[c] = rx_line_neg[c] && !cfg_q[c].pd;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                div_cnt_q[c] <= '0;
            end
            ext_prev_q <= 2'h0;
            rc_prev_q <= 2'h0;
            lp_q <= 2'h0;
            ln_q <= 2'h0;
            xcvr_mclk_tick <= 2'h0;
            recovered_clk_out <= 2'h0;
            ic_slot_clk <= '0;
            rx_multipurpose_out <= 2'h0;
            rx_serial_data_out <= 2'h0;
            rx_line_hiz <= 2'h0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            ext_prev_q <= ext_master_clk_in;
            rc_prev_q <= rec_clk_in;
            lp_q <= lp_d;
            ln_q <= ln_d;
            xcvr_mclk_tick <= mclk_d;
            recovered_clk_out <= rclk_d;
            ic_slot_clk <= slot_d;
            rx_multipurpose_out <= mp_d;
            rx_serial_data_out <= ser_d;
            rx_line_hiz <= hiz_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_mclk_int_div: assert property (
        !cfg_q[0].clk.mclk_sel && !$past(cfg_q[0].clk.mclk_sel) && xcvr_mclk_tick[0]
        |-> $past(int_master_tick) && $past(div_cnt_q[0]) == DIV_W'(MCLK_DIV - 1))
        else $error("internal master clock divide wrong");
    a_mclk_ext_src: assert property (
        cfg_q[0].clk.mclk_sel && ext_master_clk_in[0] && !ext_prev_q[0] |=> xcvr_mclk_tick[0])
        else $error("external master clock edge not taken");
    a_mclk_ext_ignore: assert property (
        !cfg_q[0].clk.mclk_sel && !div_hit[0] |=> !xcvr_mclk_tick[0])
        else $error("external master clock pin not ignored");
    a_rclk_pin_drive: assert property (
        cfg_q[0].clk.rc_en |=> recovered_clk_out[0] == $past(rec_clk_in[0]))
        else $error("recovered clock not driven");
    a_rclk_slot_route: assert property (
        cfg_q[1].dest == 4'h3 && !cfg_q[1].pd && rec_clk_in[1] ##1 cfg_q[1].dest == 4'h3
        |-> ic_slot_clk[1] == 14'h0004)
        else $error("recovered clock slot routing wrong");
    a_rclk_gpo_level: assert property (
        !cfg_q[0].clk.rc_en |=> recovered_clk_out[0] == $past(cfg_q[0].clk.rc_inv))
        else $error("recovered clock pin level wrong");
    a_mp_src_sel: assert property (
        cfg_q[1].clk.ro_en && cfg_q[1].clk.ro_src
        |=> rx_multipurpose_out[1] == $past(mframe_sync_in[1]))
        else $error("multipurpose source wrong");
    a_mp_gpo_level: assert property (
        !cfg_q[0].clk.ro_en |=> rx_multipurpose_out[0] == $past(cfg_q[0].clk.ro_inv))
        else $error("multipurpose pin level wrong");
    a_ser_nrz_edge: assert property (
        cfg_q[0].clk.rs_en && mode_ok[0] && !cfg_q[0].pd && buf_valid[0] && upd_edge[0]
        |=> rx_serial_data_out[0] == $past(buf_data[0]))
        else $error("serial data not updated on edge");
    a_ser_held_low: assert property (
        cfg_q[0].mode[`BRPC_MODE_NRZ_BIT] [*2] |-> !rx_serial_data_out[0])
        else $error("serial data not low outside mode");
    a_line_hiz_pd: assert property (
        cfg_q[1].pd |=> rx_line_hiz[1] && ic_slot_clk[1] == 14'h0000)
        else $error("line inputs not released in power-down");
    a_ch1_independent: assert property (
        !cfg_q[1].clk.rc_en |=> recovered_clk_out[1] == $past(cfg_q[1].clk.rc_inv))
        else $error("second channel pin level wrong");

endmodule : brpc_top

/* File: rtl/brpc_defs.svh */
// Offsets, field positions, reset values and timing counts of the receiver pin control
`ifndef BRPC_DEFS_SVH
`define BRPC_DEFS_SVH

// ****************************************
// Structure
// ****************************************
`define BRPC_NUM_CH 2
`define BRPC_NUM_SLOT 14
`define BRPC_BUF_DEPTH 2

// ****************************************
// Register map
// ****************************************
`define BRPC_CH_STRIDE 8'h10
`define BRPC_OFF_CLK_CTRL 8'h00
`define BRPC_OFF_CLK_ROUTE 8'h04
`define BRPC_OFF_LINE_MODE 8'h08
`define BRPC_OFF_LINE_IF 8'h0C
`define BRPC_OFF_STATUS 8'h20
`define BRPC_IDX_CLK_CTRL 2'h0
`define BRPC_IDX_CLK_ROUTE 2'h1
`define BRPC_IDX_LINE_MODE 2'h2
`define BRPC_IDX_LINE_IF 2'h3
`define BRPC_STATUS_CH_W 8

// ****************************************
// Fields and reset values
// ****************************************
`define BRPC_CLK_CTRL_W 7
`define BRPC_DEST_W 4
`define BRPC_MODE_W 2
`define BRPC_MODE_NRZ_BIT 1
`define BRPC_RST_CLK_CTRL 7'h00
`define BRPC_RST_DEST 4'h0
`define BRPC_RST_MODE 2'h0
`define BRPC_RST_PD 1'h0
`define BRPC_RESP_OKAY 2'h0
`define BRPC_RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define BRPC_INT_MCLK_KHZ 204800
`define BRPC_MCLK_DIV 100
`define BRPC_XCVR_MCLK_KHZ (`BRPC_INT_MCLK_KHZ / `BRPC_MCLK_DIV)

`endif

/* File: rtl/brpc_pkg.sv */
// Types of the receiver pin control
package brpc_pkg;

    // ****************************************
    // Control carriers
    // ****************************************
    typedef struct packed {
        logic rs_en;
        logic ro_inv;
        logic ro_src;
        logic ro_en;
        logic rc_inv;
        logic rc_en;
        logic mclk_sel;
    } brpc_clk_ctrl_t;

    typedef struct packed {
        brpc_clk_ctrl_t clk;
        logic [3:0] dest;
        logic [1:0] mode;
        logic pd;
    } brpc_chan_cfg_t;

    typedef struct packed {
        logic hit;
        logic status;
        logic ch;
        logic [1:0] idx;
    } brpc_dec_t;

    // ****************************************
    // Bus states
    // ****************************************
    typedef enum logic [1:0] {
        BRPC_ST_IDLE = 2'b01,
        BRPC_ST_RESP = 2'b10
    } brpc_bus_st_t;

endpackage : brpc_pkg

/* File: rtl/brpc_buf.sv */
// Small valid/ready buffer for received payload bits
`include "brpc_defs.svh"

module brpc_buf #(
    parameter int W = 1,
    parameter int DEPTH = `BRPC_BUF_DEPTH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic ready_d;
    logic push, pop;

    function automatic logic [PW-1:0] brpc_nxt(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : brpc_nxt

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        mem_d = mem_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push)
        begin
            mem_d[wr_q] = in_data;
        end
        wr_d = push ? brpc_nxt(wr_q) : wr_q;
        rd_d = pop ? brpc_nxt(rd_q) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = CW'(cnt_q + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
        ready_d = (cnt_d != CW'(DEPTH));
    end

    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            in_ready <= ready_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        mem_q <= mem_d;
    end

endmodule : brpc_buf

/* File: tb/brpc_board.sv */
// Board model: external master clock source and payload capture
module brpc_board (
    // Clock
    input wire logic aclk,
    // Control
    input wire logic run,
    input wire logic inv,
    // Pins
    input wire logic rclk,
    input wire logic sdata,
    output logic ext_clk,
    output logic cap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q = 2'h0;
    logic prev_q = 1'h0;
    logic cap_q = 1'h0;
    always_ff @(posedge aclk)
    begin
        div_q <= run ? div_q + 2'h1 : 2'h0;
        prev_q <= rclk;
        if (prev_q != rclk && rclk == inv)
            cap_q <= sdata;
    end
    // Held low while idle
    assign ext_clk = div_q[1];
    assign cap = cap_q;
endmodule : brpc_board

/* File: tb/brpc_top_tb_top.sv */
// Bench for the receiver pin control
module brpc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic int_master_tick = 1'h0, run = 1'h0, ext0, cap;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, xcvr_mclk_tick, rx_bit_ready, recovered_clk_out;
    logic [1:0] rx_multipurpose_out, rx_serial_data_out, rx_line_hiz;
    logic [1:0] rec_clk_in = 2'h0, frame_sync_in = 2'h0, mframe_sync_in = 2'h0;
    logic [1:0] rx_bit_in = 2'h0, rx_bit_valid = 2'h0;
    logic [1:0][13:0] ic_slot_clk;
    int error_cnt = 0;
    int checked = 0;
    int c0, c1, e;

    brpc_top #(.MCLK_DIV(4)) DUT (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .int_master_tick, .ext_master_clk_in({1'h0, ext0}),
        .xcvr_mclk_tick, .rec_clk_in, .frame_sync_in, .mframe_sync_in, .rx_bit_in,
        .rx_bit_valid, .rx_bit_ready, .rx_line_pos(2'h0), .rx_line_neg(2'h0),
        .recovered_clk_out, .ic_slot_clk, .rx_multipurpose_out, .rx_serial_data_out,
        .rx_line_hiz
    );
    brpc_board board (.aclk, .run, .inv(1'h0), .rclk(recovered_clk_out[0]),
        .sdata(rx_serial_data_out[0]), .ext_clk(ext0), .cap);

    initial forever #20 aclk = ~aclk;

    task automatic finish_test;
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic hang(input int n);
        if (n >= 50)
        begin
            chk("timeout", 32'h1, 32'h0);
            finish_test;
        end
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready === 1'h1)
                awvalid <= 1'h0;
            if (wready === 1'h1)
                wvalid <= 1'h0;
            if (bvalid === 1'h1)
                break;
        end
        bready <= 1'h0;
        chk("bresp", bresp, 32'h0);
        hang(n);
        repeat (3) @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready === 1'h1)
                arvalid <= 1'h0;
            if (rvalid === 1'h1)
                break;
        end
        rready <= 1'h0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
        hang(n);
        @(posedge aclk);
    endtask : rd

    task automatic spin;
        logic p;
        p = 1'h0;
        c0 = 0;
        c1 = 0;
        e = 0;
        for (int i = 0; i < 48; i++)
        begin
            @(posedge aclk);
            c0 += xcvr_mclk_tick[0];
            c1 += xcvr_mclk_tick[1];
            e += (ext0 & ~p);
            p = ext0;
            int_master_tick <= (i < 40);
            run <= (i < 40);
        end
    endtask : spin

    task automatic push(input logic b);
        int n;
        rx_bit_in[0] <= b;
        rx_bit_valid[0] <= 1'h1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (rx_bit_ready[0] === 1'h1)
                break;
        end
        hang(n);
        rx_bit_valid[0] <= 1'h0;
        rx_bit_in[0] <= ~b;
        @(posedge aclk);
    endtask : push

    task automatic rc(input logic v);
        rec_clk_in[0] <= v;
        repeat (3) @(posedge aclk);
    endtask : rc

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(8'h20, 32'h404, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        spin;
        chk("int_tick0", c0, 10);
        chk("int_tick1", c1, 10);
        wr(8'h00, 32'h1);
        spin;
        chk("ext_tick0", c0, e);
        chk("int_tick1b", c1, 10);
        wr(8'h14, 32'h3);
        wr(8'h10, 32'h24);
        rec_clk_in <= 2'h2;
        mframe_sync_in <= 2'h2;
        repeat (3) @(posedge aclk);
        chk("rclk_gpo", recovered_clk_out, 2'h2);
        chk("rout_gpo", rx_multipurpose_out, 2'h2);
        chk("slot", ic_slot_clk[1], 14'h4);
        wr(8'h10, 32'h1A);
        repeat (3) @(posedge aclk);
        chk("rclk_on", recovered_clk_out, 2'h2);
        chk("rout_mf", rx_multipurpose_out, 2'h2);
        wr(8'h10, 32'h0A);
        chk("rout_fs", rx_multipurpose_out, 2'h0);
        wr(8'h1C, 32'h1);
        chk("hiz", rx_line_hiz, 2'h2);
        wr(8'h00, 32'h43);
        push(1'h1);
        push(1'h0);
        chk("full", rx_bit_ready[0], 1'h0);
        rc(1'h1);
        chk("ser1", rx_serial_data_out[0], 1'h1);
        rc(1'h0);
        chk("hold", rx_serial_data_out[0], 1'h1);
        chk("cap", cap, 1'h1);
        rc(1'h1);
        chk("ser0", rx_serial_data_out[0], 1'h0);
        push(1'h1);
        rc(1'h0);
        rc(1'h1);
        chk("ser1b", rx_serial_data_out[0], 1'h1);
        wr(8'h08, 32'h2);
        chk("ser_mode", rx_serial_data_out[0], 1'h0);
        finish_test;
    end
endmodule : brpc_top_tb_top
